/* pmcs_pkg.sv */
// package: constants, enums and structs for the power-mode clock switch
package pmcs_pkg;
    // clock source select encodings
    localparam logic [1:0] SRC_PRIMARY   = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    localparam int         SRC_HI_BIT    = 1;
    localparam int         IDLE_BIT_POS  = 7;     // idle enable position in the control reg
    localparam int         FREQ_W        = 3;     // internal frequency select width
    localparam logic [2:0] FREQ_SLOW     = 3'h0;  // all zero selects the slow rc
    // timing, figures in ns, derived from the 25 MHz system clock
    localparam int CLK_PERIOD_NS           = 40;
    localparam int CPU_START_DELAY_NS      = 2000;
    localparam int INTERNAL_STABILIZE_NS   = 4000;
    localparam int CPU_START_CYCLES        =
        (CPU_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STABILIZE_CYCLES        =
        (INTERNAL_STABILIZE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OLD_CLK_CYCLES          = 2;   // transition: old clock part
    localparam int NEW_CLK_CYCLES          = 4;   // transition: new clock part, worst case
    localparam int SWITCH_CYCLES           = OLD_CLK_CYCLES + NEW_CLK_CYCLES;
    localparam int CNT_W                   = 12;

    // device clock source actually driving the clocks
    typedef enum logic [1:0] {
        CLK_PRIMARY   = 2'h0,
        CLK_INTERNAL  = 2'h1,
        CLK_SECONDARY = 2'h3,
        CLK_NONE      = 2'h2
    } clk_src_e;

    // power state, gray along run -> switch -> idle -> wake -> sleep -> resume
    typedef enum logic [2:0] {
        ST_RUN    = 3'h0,
        ST_SWITCH = 3'h1,
        ST_IDLE   = 3'h3,
        ST_WAKE   = 3'h2,
        ST_SLEEP  = 3'h6,
        ST_RESUME = 3'h7
    } pm_state_e;

    // clock-source status flags
    typedef struct packed {
        logic primary_running_flag;
        logic internal_stable_flag;
        logic secondary_running_flag;
    } status_s;

    // oscillator enables
    typedef struct packed {
        logic primary_osc_en;
        logic fast_internal_osc_en;
        logic slow_internal_rc_en;
        logic secondary_osc_en;
    } osc_en_s;
endpackage : pmcs_pkg

/* power_mode_clock_switch.sv */
// power-mode clock switch: run/idle/sleep sequencing and clock status flags
// Function
// - high select bit chooses internal mux, primary off
// - internal switch done stops primary, clears flag
// - frequency select writes take effect immediately
// - zero selects: fast output off, slow rc
// - nonzero: fast on, stable flag after interval
// - already stable fast output keeps flag set
// - internal to primary waits ready, then swaps flags
// - switches never alter idle or select bits
// - slow rc stays on for watchdog or monitor
// - sleep stops oscillator, clocks, clears all flags
// - sleep: no switch, rc/secondary kept if enabled
// - sleep wake waits source, or internal if fast-start
// - idle sleep stops cpu only, flags kept
// - idle exits on wake events, after start delay
// - watchdog timeout in idle/sleep wakes, not resets
// - primary idle keeps primary clock and flag
// - secondary idle stops primary, sets secondary flag
// - secondary wake resumes cpu on secondary oscillator
// - secondary idle without enable ignores sleep
// - secondary not running holds peripheral clocks
// - idle enable sampled at each sleep instruction
// - switch lasts two old plus four new cycles
`timescale 1ns/1ps
module power_mode_clock_switch #(
    parameter int CPU_START_CNT = pmcs_pkg::CPU_START_CYCLES,   // cpu start delay cycles
    parameter int STABILIZE_CNT = pmcs_pkg::STABILIZE_CYCLES    // fast osc settle cycles
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic [7:0]                  oscillator_control_reg, // idle bit and select
    input  wire logic [pmcs_pkg::FREQ_W-1:0] internal_freq_select,
    input  wire logic                        internal_source_select,
    input  wire logic                        secondary_osc_enable,
    input  wire logic                        sleep_exec,        // one-cycle sleep pulse
    input  wire logic                        wake_event,        // interrupt wake pulse
    input  wire logic                        watchdog_timeout,  // watchdog expiry pulse
    input  wire logic                        watchdog_enable,
    input  wire logic                        fail_safe_enable,
    input  wire logic                        two_speed_enable,
    input  wire logic                        primary_ready,     // oscillator pin, async
    input  wire logic                        secondary_ready,   // oscillator pin, async
    output logic                             cpu_clk_en,
    output logic                             periph_clk_en,
    output pmcs_pkg::clk_src_e               device_clk_src,
    output logic [pmcs_pkg::FREQ_W-1:0]      internal_freq,
    output pmcs_pkg::osc_en_s                osc_en,
    output pmcs_pkg::status_s                status,
    output logic                             watchdog_reset     // timeout while running
);
    // three-stage synchronisers for the oscillator ready pins
    logic [2:0] pri_sync;                 // primary ready shift
    logic [2:0] sec_sync;                 // secondary ready shift
    logic       pri_ok;                   // filtered primary ready
    logic       sec_ok;                   // filtered secondary ready

    // control state
    pmcs_pkg::pm_state_e state;           // power state
    logic [pmcs_pkg::CNT_W-1:0] cnt;      // shared delay counter
    logic [pmcs_pkg::CNT_W-1:0] stab_cnt; // fast internal settle counter
    logic       idle_sampled;             // idle enable caught at sleep
    logic       fast_start;               // wake clocked by the internal block for now
    logic [1:0] cur_sel;                  // select the clock currently follows

    // decoded control bits; switches only read these, never write them
    wire  [1:0] sel_raw  = oscillator_control_reg[1:0];
    wire        idle_bit = oscillator_control_reg[pmcs_pkg::IDLE_BIT_POS];
    // high bit dominates, low bit is don't-care then
    wire        want_int = sel_raw[pmcs_pkg::SRC_HI_BIT];
    wire  [1:0] sel_eff  = want_int ? 2'h2 : sel_raw;
    wire        want_sec = (sel_eff == pmcs_pkg::SRC_SECONDARY);
    wire        want_pri = (sel_eff == pmcs_pkg::SRC_PRIMARY);
    // fast internal oscillator request
    wire        fast_req = (internal_freq_select != pmcs_pkg::FREQ_SLOW)
                           || internal_source_select;
    wire        fast_stable = fast_req
                           && (stab_cnt >= STABILIZE_CNT[pmcs_pkg::CNT_W-1:0]);
    // secondary idle without the oscillator enabled is ignored
    wire        sleep_ok = sleep_exec
                           && !(idle_bit && want_sec && !secondary_osc_enable);
    wire        any_wake = wake_event || watchdog_timeout;
    wire        sel_ready = (cur_sel == pmcs_pkg::SRC_PRIMARY)   ? pri_ok :
                            (cur_sel == pmcs_pkg::SRC_SECONDARY) ? sec_ok : 1'b1;
    wire        sel_changed = (sel_eff != cur_sel);
    // new target source must be stable before a swap without sleep starts; idle entry into a new source does not wait
    // a switch from run never enters a secondary with its enable clear, even if still ringing; a sleep wake can still select it
    wire        tgt_ready = want_pri ? pri_ok
                          : (want_sec ? (sec_ok && secondary_osc_enable) : 1'b1);
    wire        cnt_done = (cnt == '0);

    // ready pins: change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pri_sync <= 3'h0;
            sec_sync <= 3'h0;
            pri_ok   <= 1'b0;
            sec_ok   <= 1'b0;
        end else begin
            pri_sync <= {pri_sync[1:0], primary_ready};
            sec_sync <= {sec_sync[1:0], secondary_ready};
            if (pri_sync[2] == pri_sync[1]) begin
                pri_ok <= pri_sync[2];
            end
            if (sec_sync[2] == sec_sync[1]) begin
                sec_ok <= sec_sync[2];
            end
        end
    end

    // fast internal settle counter, counts while requested until stable, then holds
    always_ff @(posedge sys_clk) begin
        if (rst || !fast_req) begin
            stab_cnt <= '0;
        end else if (!fast_stable) begin
            stab_cnt <= stab_cnt + 1'b1;
        end
        // no reset of the count on mode change keeps a stable flag set
    end

    // power state machine
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state        <= pmcs_pkg::ST_RUN;
            cnt          <= '0;
            idle_sampled <= 1'b0;
            cur_sel      <= pmcs_pkg::SRC_PRIMARY;
        end else begin
            case (state)
                pmcs_pkg::ST_RUN: begin
                    if (sleep_ok) begin
                        idle_sampled <= idle_bit;
                        if (idle_bit && sel_changed) begin
                            // idle into a new source switches first
                            state <= pmcs_pkg::ST_SWITCH;
                            cnt   <= pmcs_pkg::CNT_W'(pmcs_pkg::SWITCH_CYCLES);
                        end else begin
                            // sleep needs no clock switch
                            state <= idle_bit ? pmcs_pkg::ST_IDLE
                                              : pmcs_pkg::ST_SLEEP;
                        end
                    end else if (sel_changed && tgt_ready) begin
                        state <= pmcs_pkg::ST_SWITCH;
                        cnt   <= pmcs_pkg::CNT_W'(pmcs_pkg::SWITCH_CYCLES);
                    end
                end
                pmcs_pkg::ST_SWITCH: begin
                    // two old plus four new clock cycles
                    if (cnt_done) begin
                        cur_sel <= sel_eff;
                        state   <= idle_sampled && !sleep_exec ? pmcs_pkg::ST_RUN
                                                               : pmcs_pkg::ST_RUN;
                        if (idle_sampled) begin
                            state <= pmcs_pkg::ST_IDLE;
                        end
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                pmcs_pkg::ST_IDLE: begin
                    if (any_wake) begin
                        state <= pmcs_pkg::ST_WAKE;
                        cnt   <= CPU_START_CNT[pmcs_pkg::CNT_W-1:0];
                    end
                end
                pmcs_pkg::ST_SLEEP: begin
                    if (any_wake) begin
                        state   <= pmcs_pkg::ST_RESUME;
                        cur_sel <= sel_eff;
                    end
                end
                pmcs_pkg::ST_RESUME: begin
                    // wait for the source, or go on the internal block at once
                    if (sel_ready || two_speed_enable || fail_safe_enable) begin
                        state <= pmcs_pkg::ST_WAKE;
                        cnt   <= CPU_START_CNT[pmcs_pkg::CNT_W-1:0];
                    end
                end
                pmcs_pkg::ST_WAKE: begin
                    if (cnt_done) begin
                        state        <= pmcs_pkg::ST_RUN;
                        idle_sampled <= 1'b0;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= pmcs_pkg::ST_RUN;
                end
            endcase
        end
    end

    // which source drives while waiting in resume
    wire in_sleep   = (state == pmcs_pkg::ST_SLEEP);
    // fast start covers resume and the start delay, until the source is ready
    wire resume_int = ((state == pmcs_pkg::ST_RESUME) && !sel_ready
                      && (two_speed_enable || fail_safe_enable))
                      || fast_start;
    wire held_off   = in_sleep || ((state == pmcs_pkg::ST_RESUME) && !resume_int)
                      || ((cur_sel == pmcs_pkg::SRC_SECONDARY) && !sec_ok);
    wire on_pri     = (cur_sel == pmcs_pkg::SRC_PRIMARY) && !resume_int && !held_off;
    wire on_sec     = (cur_sel == pmcs_pkg::SRC_SECONDARY) && !held_off;
    wire on_int     = ((cur_sel[pmcs_pkg::SRC_HI_BIT]) || resume_int) && !held_off;

    // fast-start latch: the state machine leaves resume at once, so the
    // internal block must go on clocking until the selected source is ready
    always_ff @(posedge sys_clk) begin
        if (rst || sel_ready) begin
            fast_start <= 1'b0;
        end else if (resume_int) begin
            fast_start <= 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_clk_en     <= 1'b0;
            periph_clk_en  <= 1'b0;
            device_clk_src <= pmcs_pkg::CLK_NONE;
            internal_freq  <= pmcs_pkg::FREQ_SLOW;
            osc_en         <= '0;
            status         <= '0;
            watchdog_reset <= 1'b0;
        end else begin
            // cpu stops in idle, sleep and the start delay
            cpu_clk_en    <= !held_off && ((state == pmcs_pkg::ST_RUN)
                             || (state == pmcs_pkg::ST_SWITCH && !idle_sampled));
            periph_clk_en <= !held_off;
            device_clk_src <= held_off ? pmcs_pkg::CLK_NONE :
                              on_pri   ? pmcs_pkg::CLK_PRIMARY :
                              on_sec   ? pmcs_pkg::CLK_SECONDARY :
                                         pmcs_pkg::CLK_INTERNAL;
            internal_freq <= internal_freq_select;
            // primary stays on until the internal switch completes
            osc_en.primary_osc_en       <= !in_sleep
                && ((cur_sel == pmcs_pkg::SRC_PRIMARY) || want_pri);
            osc_en.fast_internal_osc_en <= fast_req && !in_sleep;
            osc_en.slow_internal_rc_en  <= (on_int && !fast_req)
                || watchdog_enable || fail_safe_enable;
            osc_en.secondary_osc_en     <= secondary_osc_enable;
            // flags follow the driving source; cleared in sleep
            status.primary_running_flag   <= on_pri && pri_ok;
            status.internal_stable_flag   <= on_int && fast_stable;
            status.secondary_running_flag <= on_sec;
            watchdog_reset <= watchdog_timeout && (state == pmcs_pkg::ST_RUN);
        end
    end

    // sleep clears every flag one cycle later
    sleep_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_sleep |=> (status == '0) && !periph_clk_en)
        else $error("flags or clocks active in sleep");
    // wake start delay keeps cpu off for two cycles
    start_delay_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_IDLE) && any_wake |=> !cpu_clk_en ##1 !cpu_clk_en)
        else $error("cpu restarted before start delay");
    // idle keeps cpu off
    idle_cpu_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_IDLE) |=> !cpu_clk_en)
        else $error("cpu clocked in idle");
    // ignored secondary idle sleep
    sec_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_RUN) && sleep_exec && idle_bit && want_sec
        && !secondary_osc_enable |=> (state == pmcs_pkg::ST_RUN) || (state == pmcs_pkg::ST_SWITCH))
        else $error("sleep not ignored");
    // frequency follows its select in one cycle
    freq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> internal_freq == $past(internal_freq_select))
        else $error("frequency change delayed");
    // slow-only mode never shows stable
    slow_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        !fast_req |=> !status.internal_stable_flag)
        else $error("stable flag with fast output off");
    // watchdog keeps rc on
    rc_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        watchdog_enable |=> osc_en.slow_internal_rc_en)
        else $error("slow rc stopped with watchdog on");
    // timeout in idle wakes without reset
    wdt_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_IDLE) && watchdog_timeout |=> !watchdog_reset
        && (state == pmcs_pkg::ST_WAKE))
        else $error("watchdog reset in idle");
    // switch count lasts six cycles
    switch_len_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state == pmcs_pkg::ST_SWITCH) |-> (state == pmcs_pkg::ST_SWITCH) [*6])
        else $error("switch shorter than six cycles");

    // the checks below look one cycle on, since every output is registered;
    // they hold the clock and flag outputs to the state and the select
    // cpu stays off all through sleep
    sleep_cpu_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_sleep |=> !cpu_clk_en)
        else $error("cpu clocked in sleep");
    // no device clock source in sleep
    sleep_src_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_sleep |=> device_clk_src == pmcs_pkg::CLK_NONE)
        else $error("clock source shown in sleep");
    // primary oscillator stops in sleep
    sleep_osc_a: assert property (@(posedge sys_clk) disable iff (rst)
        in_sleep |=> !osc_en.primary_osc_en)
        else $error("primary running in sleep");
    // monitor keeps rc on
    fs_rc_a: assert property (@(posedge sys_clk) disable iff (rst)
        fail_safe_enable |=> osc_en.slow_internal_rc_en)
        else $error("slow rc stopped with monitor on");
    // enabled secondary keeps running
    sec_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
        secondary_osc_enable |=> osc_en.secondary_osc_en)
        else $error("secondary stopped while enabled");
    // idle keeps peripherals clocked
    idle_periph_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_IDLE) && !held_off |=> periph_clk_en)
        else $error("peripherals stopped in idle");
    // internal run shows the internal mux
    int_src_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_RUN) && cur_sel[pmcs_pkg::SRC_HI_BIT]
        |=> device_clk_src == pmcs_pkg::CLK_INTERNAL)
        else $error("internal run on wrong source");
    // primary off once on the internal mux
    pri_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_RUN) && cur_sel[pmcs_pkg::SRC_HI_BIT] && !want_pri
        |=> !osc_en.primary_osc_en && !status.primary_running_flag)
        else $error("primary kept on internal run");
    // secondary idle flags
    sec_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_IDLE) && (cur_sel == pmcs_pkg::SRC_SECONDARY) && sec_ok
        |=> status.secondary_running_flag && !status.primary_running_flag)
        else $error("secondary idle flags wrong");
    // primary idle keeps its flag
    primary_idle_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_IDLE) && (cur_sel == pmcs_pkg::SRC_PRIMARY)
        && pri_ok && !fast_start |=> status.primary_running_flag)
        else $error("primary flag lost in idle");
    // resume without fast start withholds clocks
    resume_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (state == pmcs_pkg::ST_RESUME) && !sel_ready && !two_speed_enable
        && !fail_safe_enable |=> !periph_clk_en && !cpu_clk_en)
        else $error("clocks before source ready");
endmodule : power_mode_clock_switch

/* osc_model.sv */
// oscillator model: primary and secondary sources with start-up delays
`timescale 1ns/1ps
module osc_model #(
    parameter int PRI_START = 30,  // primary start-up cycles
    parameter int SEC_START = 20   // secondary start-up cycles
) (
    input  wire logic               sys_clk,
    input  wire pmcs_pkg::osc_en_s  osc_en,
    output logic                    primary_ready,
    output logic                    secondary_ready
);
    int unsigned pri_cnt = 0;  // cycles since primary enabled
    int unsigned sec_cnt = 0;  // cycles since secondary enabled

    // start-up counters restart whenever a source is disabled
    always_ff @(posedge sys_clk) begin
        if (!osc_en.primary_osc_en) begin
            pri_cnt <= 0;
        end else if (pri_cnt < PRI_START) begin
            pri_cnt <= pri_cnt + 1;
        end
        if (!osc_en.secondary_osc_en) begin
            sec_cnt <= 0;
        end else if (sec_cnt < SEC_START) begin
            sec_cnt <= sec_cnt + 1;
        end
    end

    // a stopped source never reports ready, so stale readiness cannot hide a hang
    assign primary_ready   = osc_en.primary_osc_en && (pri_cnt == PRI_START);
    assign secondary_ready = osc_en.secondary_osc_en && (sec_cnt == SEC_START);
endmodule : osc_model

/* power_mode_clock_switch_test.sv */
// testbench: power-mode clock switch driven against the oscillator model
`timescale 1ns/1ps
module power_mode_clock_switch_test;
    localparam int SETTLE = 80;  // covers start-up, sync and the switch
    localparam pmcs_pkg::clk_src_e SP = pmcs_pkg::CLK_PRIMARY;
    localparam pmcs_pkg::clk_src_e SI = pmcs_pkg::CLK_INTERNAL;
    localparam pmcs_pkg::clk_src_e SS = pmcs_pkg::CLK_SECONDARY;
    localparam pmcs_pkg::clk_src_e SN = pmcs_pkg::CLK_NONE;
    // one row: inputs, state after settle (and sleep), state after wake
    typedef struct packed {
        logic [7:0] ctl; logic [2:0] frq; logic isrc; logic sen; logic slp; logic wdt;
        pmcs_pkg::status_s st; pmcs_pkg::clk_src_e src; logic cpu; logic per;
        pmcs_pkg::status_s stw; pmcs_pkg::clk_src_e srcw;
    } row_s;
    row_s               rows [8];
    logic               sys_clk = 1'h0;
    logic               rst = 1'h1;
    logic [7:0]         ctl = 8'h00;
    logic [2:0]         frq = 3'h0;
    logic               isrc = 1'h0, sen = 1'h0, slp = 1'h0, wke = 1'h0, wdt = 1'h0;
    logic               wde = 1'h0, fse = 1'h0, tse = 1'h0;  // watchdog, monitor, fast start
    logic               pri_rdy, sec_rdy, cpu_en, per_en, wd_rst, seen;
    logic [2:0]         ifreq;
    pmcs_pkg::clk_src_e src;
    pmcs_pkg::osc_en_s  oen;
    pmcs_pkg::status_s  st;
    int                 num_errors = 0;
    int                 n_compared = 0;

    // 25 MHz system clock
    always #20 sys_clk = ~sys_clk;

    power_mode_clock_switch #(.CPU_START_CNT(4), .STABILIZE_CNT(8)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .oscillator_control_reg(ctl),
        .internal_freq_select(frq), .internal_source_select(isrc),
        .secondary_osc_enable(sen), .sleep_exec(slp), .wake_event(wke),
        .watchdog_timeout(wdt), .watchdog_enable(wde), .fail_safe_enable(fse),
        .two_speed_enable(tse), .primary_ready(pri_rdy), .secondary_ready(sec_rdy),
        .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .device_clk_src(src),
        .internal_freq(ifreq), .osc_en(oen), .status(st), .watchdog_reset(wd_rst));

    osc_model osc_u (.sys_clk(sys_clk), .osc_en(oen), .primary_ready(pri_rdy),
        .secondary_ready(sec_rdy));

    // shared mismatch report, four-state compare
    task automatic note(input logic [3:0] g, input logic [3:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : note
    task automatic chk_st(input pmcs_pkg::status_s g, input pmcs_pkg::status_s e);
        note({1'h0, g}, {1'h0, e});
    endtask : chk_st
    task automatic chk_src(input pmcs_pkg::clk_src_e g, input pmcs_pkg::clk_src_e e);
        note({2'h0, g}, {2'h0, e});
    endtask : chk_src
    task automatic chk_bit(input logic g, input logic e);
        note({3'h0, g}, {3'h0, e});
    endtask : chk_bit
    // sample off the active edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : settle
    // one-cycle pulse: 0 sleep, 1 interrupt wake, 2 watchdog expiry
    task automatic pulse(input int k);
        @(posedge sys_clk);
        case (k)
            0: slp <= 1'h1;
            1: wke <= 1'h1;
            default: wdt <= 1'h1;
        endcase
        @(posedge sys_clk);
        slp <= 1'h0;
        wke <= 1'h0;
        wdt <= 1'h0;
    endtask : pulse
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // hang guard, about ten times the expected run
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        $display("timeout reached");
        close_out();
    end

    initial begin
        rows = '{
            '{8'h00, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h4, SP, 1'h1, 1'h1, 3'h4, SP},
            '{8'h02, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0, SI, 1'h1, 1'h1, 3'h0, SI},
            '{8'h03, 3'h4, 1'h0, 1'h0, 1'h0, 1'h0, 3'h2, SI, 1'h1, 1'h1, 3'h2, SI},
            '{8'h82, 3'h4, 1'h0, 1'h0, 1'h1, 1'h0, 3'h2, SI, 1'h0, 1'h1, 3'h2, SI},
            '{8'h80, 3'h0, 1'h0, 1'h0, 1'h1, 1'h0, 3'h4, SP, 1'h0, 1'h1, 3'h4, SP},
            '{8'h81, 3'h0, 1'h0, 1'h1, 1'h1, 1'h1, 3'h1, SS, 1'h0, 1'h1, 3'h1, SS},
            '{8'h00, 3'h0, 1'h0, 1'h1, 1'h1, 1'h1, 3'h0, SN, 1'h0, 1'h0, 3'h4, SP},
            '{8'h01, 3'h0, 1'h1, 1'h1, 1'h0, 1'h0, 3'h1, SS, 1'h1, 1'h1, 3'h1, SS}};
        settle(20);
        chk_st(st, 3'h0);
        chk_src(src, SN);
        @(posedge sys_clk);
        rst <= 1'h0;
        settle(SETTLE);
        $display("reset test done");
        // ordinary mode rows; the secondary enable is driven in the same cycle as the row's control value
        foreach (rows[i]) begin
            @(posedge sys_clk);
            ctl <= rows[i].ctl;
            frq <= rows[i].frq;
            isrc <= rows[i].isrc;
            sen <= rows[i].sen;
            settle(SETTLE);
            if (rows[i].slp) begin
                pulse(0);
                settle(SETTLE);
            end
            chk_st(st, rows[i].st);
            chk_src(src, rows[i].src);
            chk_bit(cpu_en, rows[i].cpu);
            chk_bit(per_en, rows[i].per);
            chk_bit(oen.fast_internal_osc_en, (rows[i].frq != 3'h0) | rows[i].isrc);
            chk_bit(oen.primary_osc_en, rows[i].src == SP);
            note({1'h0, ifreq}, {1'h0, rows[i].frq});
            if (rows[i].slp) begin
                pulse(rows[i].wdt ? 2 : 1);
                settle(SETTLE);
                chk_st(st, rows[i].stw);
                chk_src(src, rows[i].srcw);
                chk_bit(cpu_en, 1'h1);
            end
            $display("row %0d done", i);
        end
        // watchdog expiry while running gives a reset, not a wake
        @(posedge sys_clk);
        ctl <= 8'h00;
        isrc <= 1'h0;
        settle(SETTLE);
        pulse(2);
        seen = 1'h0;
        repeat (4) begin
            @(negedge sys_clk);
            seen = seen | wd_rst;
        end
        chk_bit(seen, 1'h1);
        settle(SETTLE);
        $display("run watchdog test done");
        // secondary idle refused while its oscillator is off
        @(posedge sys_clk);
        sen <= 1'h0;
        ctl <= 8'h81;
        settle(SETTLE);
        pulse(0);
        settle(SETTLE);
        chk_bit(cpu_en, 1'h1);
        chk_bit(per_en, 1'h1);
        $display("refused idle test done");
        // sleep keeps rc and secondary alive; wake waits for the primary
        @(posedge sys_clk);
        ctl <= 8'h00;
        sen <= 1'h1;
        wde <= 1'h1;
        settle(SETTLE);
        chk_bit(oen.slow_internal_rc_en, 1'h1);
        pulse(0);
        settle(20);
        chk_bit(oen.slow_internal_rc_en, 1'h1);
        chk_bit(oen.secondary_osc_en, 1'h1);
        chk_st(st, 3'h0);
        pulse(1);
        settle(10);
        chk_bit(per_en, 1'h0);
        settle(SETTLE);
        chk_st(st, 3'h4);
        chk_bit(cpu_en, 1'h1);
        $display("sleep wake test done");
        // fast start: internal block clocks the wake until the primary is ready
        @(posedge sys_clk);
        tse <= 1'h1;
        pulse(0);
        settle(20);
        pulse(1);
        settle(10);
        chk_src(src, SI);
        chk_bit(per_en, 1'h1);
        settle(SETTLE);
        chk_src(src, SP);
        chk_st(st, 3'h4);
        $display("fast start test done");
        close_out();
    end
endmodule : power_mode_clock_switch_test
